// *** design/odt_orient.sv ***
// Purpose: Orientation status engine and high-pass cut-off selection
// Assumes: Register strobes come from the serial front end, one cycle each
// Notes: Debounce steps come from a divider on mclk, one pulse per step
`include "odt_params.svh"

// Operation
// - Bypass bit routes pulse data around filter
// - Smoothing bit enables pulse low-pass stage
// - High-res cut-off fixed per code
// - Normal cut-off halves with sample rate from 400 Hz to 50 Hz
// - Low-power cut-off halves per rate halving to 50 Hz
// - Status bit layout, bits 5:3 zero
// - Change flag on first detect and changes
// - Status read clears change flag
// - Quadrant encodes portrait and landscape
// - Facing side zero front, one back
// - Lockout bit reflects tilt trip
// - Fields keep updating while flag set
// - Hold result when axis exceeds 1.25g
// - Orientation fields zero at power-up
// - Detection runs only when enabled
// - Count mode decrements or clears counter
// - Eight-bit hold count, resets zero
// - Wake or sleep change clears counter
// - Step weight follows rate and mode
// - High-res step 2.5 ms, 1.25 ms at 800 Hz
// - Interrupt source follows flag and enable
module odt_orient
    import odt_pkg::*;
#(
    // Shortest debounce step in mclk cycles; shorten for simulation
    parameter int STEP_BASE_CYC = `ODT_STEP_BASE_NS / `ODT_CLK_NS
) (
    input wire logic mclk,
    input wire logic rst,
    input wire odt_reg_req_s reg_req,
    output logic [7:0] reg_rdata_ff,
    input wire odt_rate_t sample_rate,
    input wire odt_osmode_e os_mode,
    input wire logic active_mode,
    input wire logic sleep_mode,
    input wire odt_orient_s candidate,
    input wire logic over_limit,
    input wire logic orient_irq_enable,
    output logic orientation_irq_source_ff,
    output odt_orient_s orient_ff,
    output logic pulse_filter_bypass_ff,
    output logic pulse_smoothing_on_ff,
    output logic [3:0] hpf_cutoff_shift_ff
);

    // Software-written controls
    logic count_mode_ff; // Clear (1) or decrement (0) when candidate matches report
    logic orientation_on_ff; // Engine enable
    logic [7:0] orientation_hold_count_ff; // Steps a candidate must persist
    logic [1:0] cutoff_choice_ff; // High-pass cut-off code

    // Engine state
    odt_state_e state_ff;
    odt_state_e nxt_state;
    logic orientation_changed_ff;
    logic nxt_changed;
    logic [7:0] debounce_ff; // Internal debounce counter
    logic [7:0] nxt_debounce;
    odt_orient_s nxt_orient;
    logic sleep_prev_ff; // For wake/sleep edge detection
    logic wake_sleep_edge;

    // Step divider
    logic [23:0] step_cnt_ff;
    logic [23:0] step_len;
    logic step_tick;
    logic [2:0] step_shift;
    logic [3:0] cutoff_shift;

    // Register access decode
    logic rd_status;
    logic wr_config;
    logic wr_count;
    logic wr_hpf;

    assign rd_status = reg_req.rd && (reg_req.addr == `ODT_ADDR_STATUS);
    assign wr_config = reg_req.wr && (reg_req.addr == `ODT_ADDR_CONFIG);
    assign wr_count = reg_req.wr && (reg_req.addr == `ODT_ADDR_COUNT);
    assign wr_hpf = reg_req.wr && (reg_req.addr == `ODT_ADDR_HPF);

    // Rate and oversampling lookup
    odt_rate_table u_rate_table (
        .sample_rate(sample_rate),
        .os_mode(os_mode),
        .cutoff_choice(cutoff_choice_ff),
        .cutoff_shift(cutoff_shift),
        .step_shift(step_shift)
    );

    // Cut-off register, filter routing bits
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cutoff_choice_ff <= `ODT_RST_SEL;
            pulse_filter_bypass_ff <= `ODT_RST_BYPASS;
            pulse_smoothing_on_ff <= `ODT_RST_SMOOTH;
        end else if (wr_hpf) begin
            cutoff_choice_ff <= reg_req.wdata[`ODT_HP_SEL_HI:`ODT_HP_SEL_LO];
            pulse_filter_bypass_ff <= reg_req.wdata[`ODT_HP_BYPASS];
            pulse_smoothing_on_ff <= reg_req.wdata[`ODT_HP_SMOOTH];
        end
    end

    // Registered cut-off shift seen by the filter datapath
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hpf_cutoff_shift_ff <= 4'h0;
        end else begin
            hpf_cutoff_shift_ff <= cutoff_shift;
        end
    end

    // Orientation configuration register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_mode_ff <= `ODT_RST_COUNT_MODE;
            orientation_on_ff <= `ODT_RST_ENABLE;
        end else if (wr_config) begin
            count_mode_ff <= reg_req.wdata[`ODT_CF_COUNT_MODE];
            orientation_on_ff <= reg_req.wdata[`ODT_CF_ENABLE];
        end
    end

    // Debounce hold count register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            orientation_hold_count_ff <= `ODT_RST_HOLD;
        end else if (wr_count) begin
            orientation_hold_count_ff <= reg_req.wdata;
        end
    end

    // Step length: shortest step weighted by rate and mode
    // Shift rather than multiply keeps the divider to one adder
    assign step_len = 24'(STEP_BASE_CYC) << step_shift;
    assign step_tick = (step_cnt_ff >= step_len - 24'h1);

    // Step divider; restarts while the engine is idle so the first
    // step after enabling is a full one
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            step_cnt_ff <= 24'h0;
        end else if (state_ff == ODT_IDLE || wake_sleep_edge) begin
            step_cnt_ff <= 24'h0;
        end else if (step_tick) begin
            step_cnt_ff <= 24'h0;
        end else begin
            step_cnt_ff <= step_cnt_ff + 24'h1;
        end
    end

    // Wake/sleep edge tracking
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sleep_prev_ff <= 1'b0;
        end else begin
            sleep_prev_ff <= sleep_mode;
        end
    end

    assign wake_sleep_edge = sleep_prev_ff ^ sleep_mode;

    // Engine state: idle while standby or disabled
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ODT_IDLE: begin
                // Leaving idle arms the first-detection flag
                if (active_mode && orientation_on_ff) begin
                    nxt_state = ODT_FIRST;
                end
            end
            ODT_FIRST: begin
                if (!active_mode || !orientation_on_ff) begin
                    nxt_state = ODT_IDLE;
                end else if (step_tick && !over_limit) begin
                    nxt_state = ODT_TRACK;
                end
            end
            ODT_TRACK: begin
                if (!active_mode || !orientation_on_ff) begin
                    nxt_state = ODT_IDLE;
                end
            end
            default: begin
                nxt_state = ODT_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_ff <= ODT_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Debounce and result update
    // A candidate that differs from the report counts up once per
    // step; when it has persisted the hold count it is taken over
    always_comb begin
        nxt_debounce = debounce_ff;
        nxt_orient = orient_ff;
        nxt_changed = orientation_changed_ff;
        if (rd_status) begin
            nxt_changed = 1'b0;
        end
        if (wake_sleep_edge) begin
            nxt_debounce = 8'h0;
        end else if (state_ff == ODT_IDLE) begin
            nxt_debounce = 8'h0;
        end else if (step_tick && !over_limit) begin
            if (state_ff == ODT_FIRST) begin
                // First detection after going active always reports
                nxt_orient = candidate;
                nxt_changed = 1'b1;
                nxt_debounce = 8'h0;
            end else if (candidate != orient_ff) begin
                if (debounce_ff >= orientation_hold_count_ff) begin
                    // Fields update even with the flag still set
                    nxt_orient = candidate;
                    nxt_changed = 1'b1;
                    nxt_debounce = 8'h0;
                end else begin
                    nxt_debounce = debounce_ff + 8'h1;
                end
            end else if (count_mode_ff) begin
                nxt_debounce = 8'h0;
            end else if (debounce_ff != 8'h0) begin
                nxt_debounce = debounce_ff - 8'h1;
            end
        end
    end

    // Debounce counter
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            debounce_ff <= 8'h0;
        end else begin
            debounce_ff <= nxt_debounce;
        end
    end

    // Reported orientation, all zero from reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            orient_ff <= '0;
        end else begin
            orient_ff <= nxt_orient;
        end
    end

    // Change flag; a new change in the read cycle wins over the clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            orientation_changed_ff <= 1'b0;
        end else begin
            orientation_changed_ff <= nxt_changed;
        end
    end

    // Interrupt source follows the flag, gated by its enable
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            orientation_irq_source_ff <= 1'b0;
        end else begin
            orientation_irq_source_ff <= nxt_changed && orient_irq_enable;
        end
    end

    // Read data, registered; unmapped addresses read zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata_ff <= 8'h0;
        end else if (reg_req.rd) begin
            reg_rdata_ff <= 8'h0;
            unique case (reg_req.addr)
                `ODT_ADDR_STATUS: begin
                    // Bits 5:3 stay zero
                    reg_rdata_ff[`ODT_ST_CHANGED] <= orientation_changed_ff;
                    reg_rdata_ff[`ODT_ST_LOCKOUT] <= orient_ff.z_tilt_exceeded;
                    reg_rdata_ff[`ODT_ST_QUAD_HI:`ODT_ST_QUAD_LO] <=
                        orient_ff.tilt_quadrant;
                    reg_rdata_ff[`ODT_ST_FACING] <= orient_ff.facing_side;
                end
                `ODT_ADDR_CONFIG: begin
                    reg_rdata_ff[`ODT_CF_COUNT_MODE] <= count_mode_ff;
                    reg_rdata_ff[`ODT_CF_ENABLE] <= orientation_on_ff;
                end
                `ODT_ADDR_COUNT: begin
                    reg_rdata_ff <= orientation_hold_count_ff;
                end
                `ODT_ADDR_HPF: begin
                    reg_rdata_ff[`ODT_HP_BYPASS] <= pulse_filter_bypass_ff;
                    reg_rdata_ff[`ODT_HP_SMOOTH] <= pulse_smoothing_on_ff;
                    reg_rdata_ff[`ODT_HP_SEL_HI:`ODT_HP_SEL_LO] <=
                        cutoff_choice_ff;
                end
                default: begin
                    reg_rdata_ff <= 8'h0;
                end
            endcase
        end
    end

endmodule

// *** design/odt_rate_table.sv ***
// Purpose: Maps sample rate, oversampling and cut-off code to shifts
// Assumes: Purely combinational, caller registers cutoff_shift only
// Notes: Cut-off is 16 Hz right-shifted; step is 1.25 ms left-shifted
module odt_rate_table
    import odt_pkg::*;
(
    input wire odt_rate_t sample_rate,
    input wire odt_osmode_e os_mode,
    input wire logic [1:0] cutoff_choice,
    output logic [3:0] cutoff_shift,
    output logic [2:0] step_shift
);

    logic [3:0] base_cut;

    // Base cut-off for code 00, then each code halves again
    always_comb begin
        base_cut = 4'h0;
        step_shift = 3'h0;
        unique case (os_mode)
            ODT_OS_HIRES: begin
                base_cut = 4'h0;
                step_shift = (sample_rate == 3'h0) ? 3'h0 : 3'h1;
            end
            ODT_OS_LOWPWR: begin
                // Halves per rate step to 50 Hz, then 0.25 Hz
                base_cut = (sample_rate > 3'h4) ? 4'h6 : {1'b0, sample_rate};
                // 80 ms at 12.5 Hz, 160 ms below
                if (sample_rate > 3'h5) begin
                    step_shift = 3'h7;
                end else if (sample_rate == 3'h5) begin
                    step_shift = 3'h6;
                end else begin
                    step_shift = sample_rate;
                end
            end
            default: begin
                // Normal and quiet share 800..50 Hz
                if (sample_rate < 3'h2) begin
                    base_cut = 4'h0;
                end else if (sample_rate < 3'h5) begin
                    base_cut = {1'b0, sample_rate} - 4'h1;
                end else begin
                    base_cut = (os_mode == ODT_OS_QUIET) ? 4'h5 : 4'h3;
                end
                if (sample_rate < 3'h5) begin
                    step_shift = sample_rate;
                end else begin
                    step_shift = (os_mode == ODT_OS_QUIET) ? 3'h6 : 3'h4;
                end
            end
        endcase
        cutoff_shift = base_cut + {2'h0, cutoff_choice};
    end

endmodule

// *** pkg/odt_params.svh ***
// Purpose: Named constants for the orientation and high-pass select block
// Assumes: mclk at 20 MHz
// Notes: Register offsets, field positions, reset values and timing
`ifndef ODT_PARAMS_SVH
`define ODT_PARAMS_SVH

// Register offsets
`define ODT_ADDR_HPF 8'h0f
`define ODT_ADDR_STATUS 8'h10
`define ODT_ADDR_CONFIG 8'h11
`define ODT_ADDR_COUNT 8'h12

// Status field positions
`define ODT_ST_CHANGED 7
`define ODT_ST_LOCKOUT 6
`define ODT_ST_QUAD_HI 2
`define ODT_ST_QUAD_LO 1
`define ODT_ST_FACING 0

// Config field positions
`define ODT_CF_COUNT_MODE 7
`define ODT_CF_ENABLE 6

// Cut-off select field positions
`define ODT_HP_BYPASS 5
`define ODT_HP_SMOOTH 4
`define ODT_HP_SEL_HI 1
`define ODT_HP_SEL_LO 0

// Reset values
`define ODT_RST_COUNT_MODE 1'b1
`define ODT_RST_ENABLE 1'b0
`define ODT_RST_HOLD 8'h00
`define ODT_RST_SEL 2'h0
`define ODT_RST_BYPASS 1'b0
`define ODT_RST_SMOOTH 1'b0

// Timing: shortest debounce step and clock period
`define ODT_STEP_BASE_NS 1250000
`define ODT_CLK_NS 50

`endif

// *** pkg/odt_pkg.sv ***
// Purpose: Types shared by the orientation and high-pass select block
// Assumes: Nothing beyond SystemVerilog packages
// Notes: Sample rates are listed fastest first
package odt_pkg;

    // Sample rate: 800, 400, 200, 100, 50, 12.5, 6.25, 1.56 Hz
    typedef logic [2:0] odt_rate_t;

    // Oversampling mode
    typedef enum logic [1:0] {
        ODT_OS_NORMAL = 2'h0,
        ODT_OS_QUIET = 2'h1,
        ODT_OS_HIRES = 2'h2,
        ODT_OS_LOWPWR = 2'h3
    } odt_osmode_e;

    // Orientation result as reported
    typedef struct packed {
        logic z_tilt_exceeded;
        logic [1:0] tilt_quadrant;
        logic facing_side;
    } odt_orient_s;

    // Register access strobes
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } odt_reg_req_s;

    // Engine state, Gray along idle, first, track
    typedef enum logic [1:0] {
        ODT_IDLE = 2'b00,
        ODT_FIRST = 2'b01,
        ODT_TRACK = 2'b11
    } odt_state_e;

endpackage

// *** verif/odt_host_model.sv ***
// Purpose: Host side of the register byte port
// Assumes: Requests launched on the falling edge, one cycle each
// Notes: Released address and data show inverted values, never stale ones
module odt_host_model
    import odt_pkg::*;
(
    input wire logic mclk,
    output odt_reg_req_s reg_req,
    input wire logic [7:0] reg_rdata_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus at time zero
    initial reg_req = '0;
    // One byte write, strobe held across one rising edge
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge mclk);
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    // One byte read, data taken the cycle after the strobe
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge mclk);
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
        d = reg_rdata_ff;
    endtask
endmodule

// *** verif/odt_orient_sva.sv ***
// Purpose: Port checks for the orientation engine and cut-off select
// Assumes: Bound to odt_orient; one clock domain, async reset rst
// Notes: Read data lags its strobe by one cycle
`include "odt_params.svh"
module odt_orient_sva
    import odt_pkg::*;
#(
    parameter int STEP_BASE_CYC = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire odt_reg_req_s reg_req,
    input wire logic [7:0] reg_rdata_ff,
    input wire odt_rate_t sample_rate,
    input wire odt_osmode_e os_mode,
    input wire logic active_mode,
    input wire logic sleep_mode,
    input wire odt_orient_s candidate,
    input wire logic over_limit,
    input wire logic orient_irq_enable,
    input wire logic orientation_irq_source_ff,
    input wire odt_orient_s orient_ff,
    input wire logic pulse_filter_bypass_ff,
    input wire logic pulse_smoothing_on_ff,
    input wire logic [3:0] hpf_cutoff_shift_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Status read strobe, the one access with a side effect
    logic rd_st;
    assign rd_st = reg_req.rd && (reg_req.addr == `ODT_ADDR_STATUS);
    // Layout checked only when no update races the read
    AST_STATUS_LAYOUT: assert property (rd_st ##1 $stable(orient_ff) |->
        reg_rdata_ff[5:3] == 3'h0 && reg_rdata_ff[6] == orient_ff.z_tilt_exceeded &&
        reg_rdata_ff[2:0] == {orient_ff.tilt_quadrant, orient_ff.facing_side})
        else $error("status layout wrong");
    AST_RDATA_HOLD: assert property (!reg_req.rd |=> $stable(reg_rdata_ff))
        else $error("read data moved without a read");
    AST_IRQ_GATE: assert property (!$past(orient_irq_enable) |-> !orientation_irq_source_ff)
        else $error("irq source high while disabled");
    // Engine idle for two cycles, so no new change can win over the clear
    AST_READ_CLEARS: assert property (rd_st && !active_mode && !$past(active_mode)
        && !$past(active_mode, 2) |=> !orientation_irq_source_ff)
        else $error("status read left irq source set");
    AST_LOCK_FREEZE: assert property ($changed(orient_ff) |-> !$past(over_limit))
        else $error("orientation moved above limit");
    AST_RUN_ACTIVE: assert property ($changed(orient_ff) |->
        $past(active_mode) || $past(active_mode, 2))
        else $error("orientation moved while standby");
    AST_TAKE_CAND: assert property ($changed(orient_ff) |-> orient_ff == $past(candidate))
        else $error("reported orientation not the candidate");
    AST_CHANGE_IRQ: assert property ($changed(orient_ff) && $past(orient_irq_enable)
        |-> orientation_irq_source_ff)
        else $error("change did not raise irq source");
    AST_RESET_ZERO: assert property ($past(rst) |-> orient_ff == 4'h0 &&
        !orientation_irq_source_ff && reg_rdata_ff == 8'h00)
        else $error("outputs not zero after reset");
    AST_HPF_BITS: assert property (reg_req.wr && reg_req.addr == `ODT_ADDR_HPF |=>
        pulse_filter_bypass_ff == $past(reg_req.wdata[5]) &&
        pulse_smoothing_on_ff == $past(reg_req.wdata[4]))
        else $error("filter bits not taken from write");
    // Main scenarios reached
    COV_READ: cover property (rd_st);
    COV_CHANGE: cover property ($changed(orient_ff));
    COV_IRQ: cover property (orientation_irq_source_ff);
endmodule

bind odt_orient odt_orient_sva #(.STEP_BASE_CYC(STEP_BASE_CYC)) u_odt_orient_sva (
    .mclk(mclk), .rst(rst), .reg_req(reg_req), .reg_rdata_ff(reg_rdata_ff),
    .sample_rate(sample_rate), .os_mode(os_mode), .active_mode(active_mode),
    .sleep_mode(sleep_mode), .candidate(candidate), .over_limit(over_limit),
    .orient_irq_enable(orient_irq_enable),
    .orientation_irq_source_ff(orientation_irq_source_ff), .orient_ff(orient_ff),
    .pulse_filter_bypass_ff(pulse_filter_bypass_ff),
    .pulse_smoothing_on_ff(pulse_smoothing_on_ff),
    .hpf_cutoff_shift_ff(hpf_cutoff_shift_ff)
);

// *** verif/testbench.sv ***
// Purpose: Register and orientation sequences for odt_orient
// Assumes: Short debounce step of 4 mclk cycles
// Notes: Expected cut-off shifts are worked out here from the rate tables
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import odt_pkg::*;
    localparam int STEP = 4;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    odt_reg_req_s reg_req;
    logic [7:0] rdata;
    odt_rate_t sample_rate = 3'h0;
    odt_osmode_e os_mode = ODT_OS_NORMAL;
    logic active_mode = 1'b0;
    logic sleep_mode = 1'b0;
    odt_orient_s candidate = 4'h0;
    logic over_limit = 1'b0;
    logic irq_en = 1'b1;
    logic irq;
    odt_orient_s orient;
    logic byp;
    logic smo;
    logic [3:0] shift;
    int bad_count = 0;
    int total_checks = 0;
    // Debounce cases: rate, mode, hold count, step length, new candidate
    int e_rate [5] = '{0, 1, 3, 5, 6};
    int e_mode [5] = '{0, 0, 2, 1, 3};
    int e_hold [5] = '{2, 1, 1, 0, 0};
    int e_step [5] = '{STEP, 2 * STEP, 2 * STEP, 64 * STEP, 128 * STEP};
    logic [3:0] e_cand [5] = '{4'h3, 4'h5, 4'hc, 4'h6, 4'h9};
    // 20 MHz clock
    always #25 mclk = ~mclk;
    odt_orient #(.STEP_BASE_CYC(STEP)) u_odt_orient (
        .mclk(mclk), .rst(rst), .reg_req(reg_req), .reg_rdata_ff(rdata),
        .sample_rate(sample_rate), .os_mode(os_mode), .active_mode(active_mode),
        .sleep_mode(sleep_mode), .candidate(candidate), .over_limit(over_limit),
        .orient_irq_enable(irq_en), .orientation_irq_source_ff(irq), .orient_ff(orient),
        .pulse_filter_bypass_ff(byp), .pulse_smoothing_on_ff(smo),
        .hpf_cutoff_shift_ff(shift)
    );
    odt_host_model u_host (.mclk(mclk), .reg_req(reg_req), .reg_rdata_ff(rdata));
    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.read(a, d);
        chk(d, exp);
    endtask
    // Wait for the report to take c; the wait must land in (lo, hi] cycles
    task automatic wait_upd(input logic [3:0] c, input int lo, input int hi);
        int n;
        n = 0;
        while (orient !== c && n <= hi) begin
            @(negedge mclk);
            n++;
        end
        chk(8'(n > lo && n <= hi), 8'h01);
    endtask
    // Cut-off as a right shift of 16 Hz
    function automatic logic [3:0] exp_shift(int m, int r, int s);
        int b;
        case (m)
            2: b = 0;
            3: b = (r > 4) ? 6 : r;
            1: b = (r > 4) ? 5 : ((r < 2) ? 0 : r - 1);
            default: b = (r > 4) ? 3 : ((r < 2) ? 0 : r - 1);
        endcase
        return 4'(b + s);
    endfunction
    task automatic conclude();
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Watchdog at 20000 cycles, more than ten times the 1500 or so cycles the run needs
    initial begin
        #1_000_000;
        bad_count++;
        conclude();
    end
    // Main sequence
    initial begin
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        rd_chk(8'h0f, 8'h00);
        rd_chk(8'h10, 8'h00);
        rd_chk(8'h11, 8'h80);
        rd_chk(8'h12, 8'h00);
        rd_chk(8'h20, 8'h00);
        u_host.write(8'h10, 8'hff);
        rd_chk(8'h10, 8'h00);
        u_host.write(8'h12, 8'ha5);
        rd_chk(8'h12, 8'ha5);
        u_host.write(8'h11, 8'hff);
        rd_chk(8'h11, 8'hc0);
        u_host.write(8'h11, 8'h80);
        // Every mode, rate and code of the cut-off table
        for (int m = 0; m < 4; m++) begin
            for (int r = 0; r < 8; r++) begin
                for (int s = 0; s < 4; s++) begin
                    os_mode = odt_osmode_e'(2'(m));
                    sample_rate = 3'(r);
                    u_host.write(8'h0f, {2'b00, 2'(s), 2'b00, 2'(s)});
                    @(negedge mclk);
                    chk({4'h0, shift}, {4'h0, exp_shift(m, r, s)});
                    chk({6'h0, byp, smo}, 8'(s));
                end
            end
        end
        u_host.write(8'h0f, 8'h3f);
        rd_chk(8'h0f, 8'h33);
        // Active but disabled: nothing reported
        os_mode = ODT_OS_NORMAL;
        sample_rate = 3'h0;
        active_mode = 1'b1;
        repeat (4 * STEP) @(negedge mclk);
        chk({7'h0, irq}, 8'h00);
        u_host.write(8'h11, 8'hc0);
        repeat (4 * STEP) @(negedge mclk);
        chk({7'h0, irq}, 8'h01);
        rd_chk(8'h10, 8'h80);
        chk({7'h0, irq}, 8'h00);
        // Debounce latency scales with hold count and step weight
        for (int i = 0; i < 5; i++) begin
            sample_rate = 3'(e_rate[i]);
            os_mode = odt_osmode_e'(2'(e_mode[i]));
            u_host.write(8'h12, 8'(e_hold[i]));
            candidate = e_cand[i];
            wait_upd(e_cand[i], e_hold[i] * e_step[i], (e_hold[i] + 2) * e_step[i]);
            chk({7'h0, irq}, 8'h01);
            rd_chk(8'h10, {1'b1, e_cand[i][3], 3'h0, e_cand[i][2:0]});
            rd_chk(8'h10, {1'b0, e_cand[i][3], 3'h0, e_cand[i][2:0]});
        end
        // Above the g limit the report is frozen
        sample_rate = 3'h0;
        os_mode = ODT_OS_NORMAL;
        u_host.write(8'h12, 8'h00);
        over_limit = 1'b1;
        candidate = 4'h2;
        repeat (4 * STEP) @(negedge mclk);
        chk({4'h0, orient}, 8'h09);
        irq_en = 1'b0;
        over_limit = 1'b0;
        wait_upd(4'h2, 0, 2 * STEP);
        chk({7'h0, irq}, 8'h00);
        // Second change while the flag is still unread
        candidate = 4'h7;
        wait_upd(4'h7, 0, 2 * STEP);
        rd_chk(8'h10, 8'h87);
        // Sleep change mid-count restarts the debounce
        u_host.write(8'h12, 8'h02);
        candidate = 4'h4;
        repeat (6) @(negedge mclk);
        sleep_mode = 1'b1;
        wait_upd(4'h4, 2 * STEP, 4 * STEP);
        // Decrement mode: one matching step only backs the count off by one
        u_host.write(8'h11, 8'h40);
        rd_chk(8'h11, 8'h40);
        // Wake edge restarts the divider, so steps land at known edges
        sleep_mode = 1'b0;
        candidate = 4'h1;
        repeat (10) @(negedge mclk);
        candidate = 4'h4;
        repeat (4) @(negedge mclk);
        candidate = 4'h1;
        wait_upd(4'h1, STEP, 2 * STEP);
        // Standby read clears the raised source; going active reports again
        active_mode = 1'b0;
        irq_en = 1'b1;
        repeat (4) @(negedge mclk);
        chk({7'h0, irq}, 8'h01);
        rd_chk(8'h10, 8'h81);
        chk({7'h0, irq}, 8'h00);
        active_mode = 1'b1;
        repeat (2 * STEP) @(negedge mclk);
        chk({7'h0, irq}, 8'h01);
        conclude();
    end
endmodule
